// [common/usb_pwr_irq_pkg.sv]
// shared constants and carrier types for the usb power and interrupt flag block
package usb_pwr_irq_pkg;

	// register byte offsets on the avalon word bus
	localparam logic [3:0] OFF_POWER_CONTROL = 4'h0;
	localparam logic [3:0] OFF_INT_FLAGS = 4'h4;
	localparam logic [3:0] OFF_INT_ENABLE = 4'h8;
	localparam logic [3:0] OFF_ERR_ENABLE = 4'hc;

	// power control field positions
	localparam int PWR_ENABLE_BIT = 0;
	localparam int PWR_SUSPEND_BIT = 1;
	localparam int PWR_BUSY_BIT = 3;
	localparam int PWR_GUARD_BIT = 4;
	localparam int PWR_PENDING_BIT = 7;

	// interrupt flag field positions
	localparam int FLG_RESET_DETACH = 0;
	localparam int FLG_ERROR = 1;
	localparam int FLG_FRAME = 2;
	localparam int FLG_TOKEN = 3;
	localparam int FLG_IDLE = 4;
	localparam int FLG_RESUME = 5;
	localparam int FLG_ATTACH = 6;
	localparam int FLG_STALL = 7;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// timing at 10 mhz
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESUME_TIME_NS = 2500;
	localparam int ATTACH_QUIET_NS = 2500;
	localparam int IDLE_TIME_NS = 3000000;
	localparam int RESUME_CYCLES = (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ATTACH_CYCLES = (ATTACH_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_CYCLES_DEFAULT = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_SETTLE_CYCLES = 4;

	// cable line state
	typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K, LINE_SE1} line_state_t;

	// hardware events from the token engine and line monitor
	typedef struct packed {
		logic stall_seen;
		logic token_done;
		logic sof_seen;
		logic bus_reset;
		logic detach_seen;
		logic [7:0] err_raw;
	} usb_events_t;

	// power side outputs
	typedef struct packed {
		logic clk48_gate_en;
		logic xcvr_low_power;
		logic pins_owned;
		logic analog_on;
		logic sleep_block;
	} power_out_t;

endpackage : usb_pwr_irq_pkg

// [hw/line_timer.sv]
// saturating timer that reports when a condition has held for a cycle count
`timescale 1ns/1ps
`default_nettype none
module line_timer
	import usb_pwr_irq_pkg::*;
#(
	parameter int LIMIT = 25
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic cond,
	output logic reached
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// count while the condition holds, restart when it drops
	assign cnt_d = !cond ? '0 : (cnt_q == LIM) ? cnt_q : cnt_q + 1'b1;
	assign reached = (cnt_q == LIM);

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end
endmodule : line_timer
`default_nettype wire

// [hw/usb_power_and_interrupt_flags.sv]
// power control and write-one-to-clear interrupt flags of the usb controller
// Notes on behaviour
// (R1) bit 7 reads one when bus activity seen but its interrupt not yet raised
// (R2) guard bit 4 set blocks sleep during activity or pending notification
// (R3) busy bit 3 reads one while active or still settling after disable
// (R4) suspend bit 1 gates 48 MHz clock and puts transceiver in low power
// (R5) enable bit 0 low holds outputs inactive, frees pins, analog off
// (R6) software must not trust or write other registers while disabled and busy
// (R7) flags set by hardware, cleared by writing one, zero writes ignored
// (R8) error summary bit 1 read-only, set only by enabled error sources
// (R9) stall flag bit 7 on stall handshake received as host or sent as device
// (R10) attach flag bit 6 in host mode after 2.5 us quiet, bus not SE0
// (R11) resume flag bit 5 after K-state held 2.5 us
// (R12) software should keep resume interrupt disabled outside suspend
// (R13) idle flag bit 4 after constant idle of 3 ms or more
// (R14) token flag bit 3 on token completion; clearing it advances status fifo
// (R15) frame flag bit 2 on SOF received as device or threshold as host
// (R16) device mode: bit 0 set on valid bus reset
// (R17) host mode: bit 0 set on peripheral detach
// (R18) bits 31-8 and unused positions read zero, writes ignored
// (R19) error summary reaches the combined request only when its enable is set
// (R20) combined request high while any flag and its enable are both set
`timescale 1ns/1ps
`default_nettype none
module usb_power_and_interrupt_flags
	import usb_pwr_irq_pkg::*;
#(
	parameter int IDLE_CYCLES = IDLE_CYCLES_DEFAULT
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic host_operation_enable,
	input wire line_state_t line_state,
	input wire logic bus_active,
	input wire logic engine_busy,
	input wire usb_events_t events,
	output logic stat_fifo_advance,
	output logic combined_usb_irq,
	output power_out_t power_out
);
	// registers
	logic module_enable_q;
	logic suspend_request_q;
	logic sleep_entry_guard_q;
	logic activity_pending_q;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] int_enable_q;
	logic [7:0] err_enable_q;
	logic [2:0] settle_q;
	logic busy_q;
	logic ack_q;
	logic wait_q;
	logic irq_q;
	logic adv_q;
	power_out_t pwr_q;

	// bus decode
	wire sel_pwr = (avs_address == OFF_POWER_CONTROL);
	wire sel_flg = (avs_address == OFF_INT_FLAGS);
	wire sel_ien = (avs_address == OFF_INT_ENABLE);
	wire sel_een = (avs_address == OFF_ERR_ENABLE);
	wire req = (avs_read | avs_write) & ~ack_q;
	wire wr_now = avs_write & ~ack_q;

	// read mux; unused positions and bits 31-8 stay zero
	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h000000, v};
	endfunction : zext8
	wire [7:0] pwr_view = {activity_pending_q, 2'b00, sleep_entry_guard_q, busy_q,
		1'b0, suspend_request_q, module_enable_q};
	wire [31:0] rd_mux = sel_pwr ? zext8(pwr_view) : sel_flg ? zext8(flags_q) :
		sel_ien ? zext8(int_enable_q) : sel_een ? zext8(err_enable_q) : 32'h00000000; // [R18]

	// line timers
	wire k_seen;
	wire quiet_ok;
	wire idle_ok;
	line_timer #(.LIMIT(RESUME_CYCLES)) u_resume_t (
		.clk(clk), .srst(srst), .ce(ce),
		.cond(module_enable_q && line_state == LINE_K),
		.reached(k_seen)
	); // [R11]
	line_timer #(.LIMIT(ATTACH_CYCLES)) u_attach_t (
		.clk(clk), .srst(srst), .ce(ce),
		.cond(module_enable_q && host_operation_enable && !bus_active && line_state != LINE_SE0),
		.reached(quiet_ok)
	); // [R10]
	line_timer #(.LIMIT(IDLE_CYCLES)) u_idle_t (
		.clk(clk), .srst(srst), .ce(ce),
		.cond(module_enable_q && line_state == LINE_J && !bus_active),
		.reached(idle_ok)
	); // [R13]

	// event sources, all gated by the module enable
	wire [7:0] hw_set;
	assign hw_set[FLG_STALL] = events.stall_seen; // [R9]
	assign hw_set[FLG_ATTACH] = quiet_ok; // [R10]
	assign hw_set[FLG_RESUME] = k_seen; // [R11]
	assign hw_set[FLG_IDLE] = idle_ok; // [R13]
	assign hw_set[FLG_TOKEN] = events.token_done; // [R14]
	assign hw_set[FLG_FRAME] = events.sof_seen; // [R15]
	assign hw_set[FLG_ERROR] = |(events.err_raw & err_enable_q); // [R8]
	assign hw_set[FLG_RESET_DETACH] = host_operation_enable ? events.detach_seen : events.bus_reset; // [R16] [R17]
	wire [7:0] set_v = module_enable_q ? hw_set : 8'h00;

	// write one clears; error summary is read-only so never cleared by write
	wire [7:0] clr_mask = (wr_now && sel_flg) ? (avs_writedata[7:0] & 8'hfd) : 8'h00; // [R7] [R8]
	assign flags_d = (flags_q & ~clr_mask) | set_v; // [R7]
	wire token_clear = clr_mask[FLG_TOKEN] & flags_q[FLG_TOKEN]; // [R14]
	wire irq_d = |(flags_d & int_enable_q); // [R19] [R20]
	wire any_event = bus_active | (|set_v);
	wire busy_d = module_enable_q | engine_busy | (settle_q != 3'h0); // [R3]

	// bus handshake: one wait cycle then acknowledge; waitrequest kept in its own flop
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q <= 1'b0;
			wait_q <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if (ce) begin
			ack_q <= req;
			wait_q <= ~req;
			avs_readdata <= req ? rd_mux : avs_readdata;
		end
	end
	assign avs_waitrequest = wait_q;

	// software writable controls
	always_ff @(posedge clk) begin
		if (srst) begin
			module_enable_q <= 1'b0;
			suspend_request_q <= 1'b0;
			sleep_entry_guard_q <= 1'b0;
			int_enable_q <= RST_BYTE;
			err_enable_q <= RST_BYTE;
		end else if (ce && wr_now) begin
			if (sel_pwr) begin
				module_enable_q <= avs_writedata[PWR_ENABLE_BIT];
				suspend_request_q <= avs_writedata[PWR_SUSPEND_BIT];
				sleep_entry_guard_q <= avs_writedata[PWR_GUARD_BIT];
			end else if (sel_ien) begin
				int_enable_q <= avs_writedata[7:0];
			end else if (sel_een) begin
				err_enable_q <= avs_writedata[7:0];
			end
		end
	end

	// flags and busy; set wins over a simultaneous clear
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_q <= RST_BYTE; // [R7]
			settle_q <= 3'h0;
			busy_q <= 1'b0;
			irq_q <= 1'b0;
			adv_q <= 1'b0;
		end else if (ce) begin
			flags_q <= flags_d;
			settle_q <= module_enable_q ? 3'(BUSY_SETTLE_CYCLES) : (settle_q != 3'h0 ? settle_q - 3'h1 : 3'h0); // [R3]
			busy_q <= busy_d;
			irq_q <= irq_d;
			adv_q <= token_clear; // [R14]
		end
	end

	// activity pending: seen activity whose interrupt not yet visible
	always_ff @(posedge clk) begin
		if (srst) begin
			activity_pending_q <= 1'b0;
		end else if (ce) begin
			activity_pending_q <= module_enable_q & any_event & ~irq_d; // [R1]
		end
	end

	// power outputs; disabled state forces everything inactive
	always_ff @(posedge clk) begin
		if (srst) begin
			pwr_q <= '0;
		end else if (ce) begin
			pwr_q.clk48_gate_en <= module_enable_q & ~suspend_request_q; // [R4] [R5]
			pwr_q.xcvr_low_power <= ~module_enable_q | suspend_request_q; // [R4]
			pwr_q.pins_owned <= module_enable_q; // [R5]
			pwr_q.analog_on <= module_enable_q; // [R5]
			pwr_q.sleep_block <= sleep_entry_guard_q & module_enable_q &
				(any_event | activity_pending_q | irq_d); // [R2]
		end
	end
	assign power_out = pwr_q;
	assign combined_usb_irq = irq_q;
	assign stat_fifo_advance = adv_q;

	chk_write_clears_flag: assert property (@(posedge clk) disable iff (srst)
		ce && wr_now && sel_flg && avs_writedata[FLG_STALL] && !set_v[FLG_STALL] |=> !flags_q[FLG_STALL])
		else $error("stall flag not cleared by write one"); // [R7]
	chk_zero_write_keeps: assert property (@(posedge clk) disable iff (srst)
		ce && flags_q[FLG_IDLE] |=> flags_q[FLG_IDLE] || $past(clr_mask[FLG_IDLE]))
		else $error("idle flag dropped without clear"); // [R7]
	chk_error_masked: assert property (@(posedge clk) disable iff (srst)
		ce && !flags_q[FLG_ERROR] && !(|(events.err_raw & err_enable_q)) |=> !flags_q[FLG_ERROR])
		else $error("error summary set by masked source"); // [R8]
	chk_suspend_gates_clk: assert property (@(posedge clk) disable iff (srst)
		ce && suspend_request_q |=> !power_out.clk48_gate_en && power_out.xcvr_low_power)
		else $error("suspend did not gate clock"); // [R4]
	chk_disable_inactive: assert property (@(posedge clk) disable iff (srst)
		ce && !module_enable_q |=> !power_out.pins_owned && !power_out.analog_on && flags_q == $past(flags_d))
		else $error("outputs active while disabled"); // [R5]
	chk_busy_settles: assert property (@(posedge clk) disable iff (srst)
		ce && module_enable_q |=> busy_q)
		else $error("busy low while enabled"); // [R3]
	chk_guard_off_free: assert property (@(posedge clk) disable iff (srst)
		ce && !sleep_entry_guard_q |=> !power_out.sleep_block)
		else $error("sleep blocked with guard clear"); // [R2]
	chk_irq_follows: assert property (@(posedge clk) disable iff (srst)
		ce |=> combined_usb_irq == |($past(flags_d) & $past(int_enable_q)))
		else $error("combined request wrong"); // [R19] [R20]
	chk_token_advance: assert property (@(posedge clk) disable iff (srst)
		ce && token_clear |=> stat_fifo_advance ##1 !stat_fifo_advance || $past(token_clear))
		else $error("status fifo advance missing"); // [R14]
	chk_resume_timed: assert property (@(posedge clk) disable iff (srst)
		ce && module_enable_q && k_seen |=> flags_q[FLG_RESUME])
		else $error("resume flag not set"); // [R11]
	chk_unused_zero: assert property (@(posedge clk) disable iff (srst)
		!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits nonzero"); // [R18]
endmodule : usb_power_and_interrupt_flags
`default_nettype wire

// [testbench/usb_cable_model.sv]
// cable-side partner: line levels, activity and token engine event pulses
`timescale 1ns/1ps
`default_nettype none
module usb_cable_model
	import usb_pwr_irq_pkg::*;
(
	input wire logic clk,
	output line_state_t line_state,
	output logic bus_active,
	output usb_events_t events
);
	// cable rests in se0 so no timer runs unasked
	initial begin
		line_state = LINE_SE0;
		bus_active = 1'b0;
		events = '0;
	end
	// one-cycle event pulse, struct order stall..err
	task automatic pulse(input logic [12:0] ev);
		@(posedge clk);
		events <= ev;
		@(posedge clk);
		events <= '0;
	endtask : pulse
	// hold a line level n cycles, then back to se0
	task automatic hold(input line_state_t ls, input int n);
		@(posedge clk);
		line_state <= ls;
		repeat (n) @(posedge clk);
		line_state <= LINE_SE0;
	endtask : hold
	task automatic set_act(input logic b);
		@(posedge clk);
		bus_active <= b;
	endtask : set_act
endmodule : usb_cable_model
`default_nettype wire

// [testbench/tb_usb_power_and_interrupt_flags.sv]
// self-checking bench for the power control and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_power_and_interrupt_flags
	import usb_pwr_irq_pkg::*;
;
	logic clk = 1'b0;
	logic srst, ce, avs_read, avs_write, avs_waitrequest, host_operation_enable, bus_active, engine_busy;
	logic stat_fifo_advance, combined_usb_irq;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d, r, a0, n_adv;
	line_state_t line_state;
	usb_events_t events;
	power_out_t power_out;
	logic [32:0] ent;
	logic [32:0] exp_q[$];
	int n_mismatch = 0, n_checks = 0, seed = 5, i, k;
	logic [12:0] ev[4] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200};
	logic [7:0] fl[4] = '{8'h80, 8'h08, 8'h04, 8'h01};
	line_state_t tl[6] = '{LINE_J, LINE_J, LINE_K, LINE_K, LINE_J, LINE_J};
	logic th[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	int tn[6] = '{20, 30, 20, 30, 30, 45};
	logic [7:0] te[6] = '{8'h00, 8'h40, 8'h00, 8'h20, 8'h00, 8'h10};
	// short idle count keeps the run brief
	usb_power_and_interrupt_flags #(.IDLE_CYCLES(40)) usb_power_and_interrupt_flags_inst (.clk(clk), .srst(srst),
		.ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_operation_enable(host_operation_enable),
		.line_state(line_state), .bus_active(bus_active), .engine_busy(engine_busy), .events(events),
		.stat_fifo_advance(stat_fifo_advance), .combined_usb_irq(combined_usb_irq), .power_out(power_out));
	usb_cable_model usb_cable_model_inst (.clk(clk), .line_state(line_state), .bus_active(bus_active), .events(events));
	always #50 clk = ~clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rv);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			final_report();
		end
		rv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] wd);
		bus(a, 1'b1, wd, r);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic c);
		exp_q.push_back({c, e});
		bus(a, 1'b0, 32'h0, r);
	endtask : rd
	// scoreboard: oldest note against each answered read
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			if (ent[32]) check(avs_readdata, ent[31:0]);
		end
	end
	always @(posedge clk) if (stat_fifo_advance === 1'b1) n_adv <= n_adv + 32'h1;
	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	initial begin
		srst = 1'b1; ce = 1'b1; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
		host_operation_enable = 1'b0; engine_busy = 1'b0; n_adv = 32'h0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(OFF_POWER_CONTROL, 32'h0, 1'b1);
		rd(OFF_INT_FLAGS, 32'h0, 1'b1);
		rd(4'h2, 32'h0, 1'b1);
		check({27'h0, power_out}, 32'h08);
		for (i = 0; i < 3; i++) begin
			d = $random(seed);
			wr(OFF_INT_ENABLE, d);
			rd(OFF_INT_ENABLE, {24'h0, d[7:0]}, 1'b1);
		end
		wr(OFF_INT_ENABLE, 32'hdd); // resume kept off outside suspend
		wr(OFF_POWER_CONTROL, 32'hffffffff);
		usb_cable_model_inst.set_act(1'b1);
		rd(OFF_POWER_CONTROL, 32'h9b, 1'b1);
		check({27'h0, power_out}, 32'h0f);
		wr(OFF_POWER_CONTROL, 32'h1);
		rd(OFF_POWER_CONTROL, 32'h89, 1'b1);
		check({27'h0, power_out}, 32'h16);
		usb_cable_model_inst.set_act(1'b0);
		rd(OFF_POWER_CONTROL, 32'h09, 1'b1);
		for (i = 0; i < 4; i++) begin
			usb_cable_model_inst.pulse(ev[i]);
			wr(OFF_INT_FLAGS, {24'hffffff, ~fl[i]});
			rd(OFF_INT_FLAGS, {24'h0, fl[i]}, 1'b1);
			check({31'h0, combined_usb_irq}, 32'h1);
			a0 = n_adv;
			wr(OFF_INT_FLAGS, {24'h0, fl[i]});
			rd(OFF_INT_FLAGS, 32'h0, 1'b1);
			check({31'h0, combined_usb_irq}, 32'h0);
			check(n_adv - a0, {31'h0, i == 1});
		end
		wr(OFF_INT_ENABLE, 32'h0);
		usb_cable_model_inst.pulse(13'h1100);
		rd(OFF_INT_FLAGS, 32'h80, 1'b1);
		check({31'h0, combined_usb_irq}, 32'h0);
		wr(OFF_INT_FLAGS, 32'hff);
		host_operation_enable <= 1'b1;
		usb_cable_model_inst.pulse(13'h0100);
		rd(OFF_INT_FLAGS, 32'h01, 1'b1);
		wr(OFF_INT_FLAGS, 32'hff);
		// line-state timers (attach, resume, idle) against their bounds
		for (i = 0; i < 6; i++) begin
			host_operation_enable <= th[i];
			usb_cable_model_inst.hold(tl[i], tn[i]);
			rd(OFF_INT_FLAGS, {24'h0, te[i]}, 1'b1);
			wr(OFF_INT_FLAGS, 32'hff);
		end
		// frozen clock enable must swallow an event pulse
		ce <= 1'b0;
		usb_cable_model_inst.pulse(13'h1000);
		ce <= 1'b1;
		rd(OFF_INT_FLAGS, 32'h0, 1'b1);
		wr(OFF_ERR_ENABLE, 32'h1);
		usb_cable_model_inst.pulse(13'h0002);
		rd(OFF_INT_FLAGS, 32'h0, 1'b1);
		usb_cable_model_inst.pulse(13'h0001);
		wr(OFF_INT_FLAGS, 32'h02);
		rd(OFF_INT_FLAGS, 32'h02, 1'b1);
		check({31'h0, combined_usb_irq}, 32'h0);
		wr(OFF_INT_ENABLE, 32'h02);
		// request flop settles one edge after the enable write is acknowledged
		@(posedge clk);
		check({31'h0, combined_usb_irq}, 32'h1);
		engine_busy <= 1'b1;
		wr(OFF_POWER_CONTROL, 32'h0);
		repeat (10) @(posedge clk);
		rd(OFF_POWER_CONTROL, 32'h08, 1'b1);
		check({27'h0, power_out}, 32'h08);
		engine_busy <= 1'b0;
		// nothing else touched until busy drops
		k = 0;
		do begin
			rd(OFF_POWER_CONTROL, 32'h0, 1'b0);
			k++;
		end while (r[3] !== 1'b0 && k < 20);
		check(r, 32'h0);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_INT_FLAGS, 32'h0, 1'b1);
		final_report();
	end
endmodule : tb_usb_power_and_interrupt_flags
`default_nettype wire
